// ### design/dual_mode_control_port.v
// Dual mode serial control port with register access and alert pin
`timescale 1ns/1ns
`include "dual_mode_control_port_regs.vh"
module dual_mode_control_port
(
  input wire mclk,
  input wire rstn,
  input wire port_bit_clock,
  input wire port_serial_in,
  input wire select_strap_pin,
  input wire address_strap_1,
  input wire preemp_indicator_pin,
  output reg port_serial_out,
  output reg port_serial_out_oe_n,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  output reg [7:0] wr_data,
  output reg [6:0] wr_addr,
  output reg wr_strobe,
  output reg [6:0] rd_addr,
  input wire [7:0] rd_data,
  output reg [7:0] pointer_q,
  output reg spi_mode_q,
  input wire [7:0] alert_src,
  input wire [7:0] alert_mask,
  input wire [15:0] alert_mode,
  input wire [1:0] alert_pin_style,
  output reg alert_out,
  output reg alert_oe_n
);
  // ==========================================================
  // Input synchronisers
  // ==========================================================
  wire clk_lvl;
  wire clk_rise;
  wire clk_fall;
  wire sel_lvl;
  wire sel_fall;
  wire din_lvl;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;
  wire ad1_lvl;
  pin_sync u_clk (.mclk(mclk), .rstn(rstn), .pin(port_bit_clock), .level_q(clk_lvl),
    .rise(clk_rise), .fall(clk_fall));
  pin_sync u_sel (.mclk(mclk), .rstn(rstn), .pin(select_strap_pin), .level_q(sel_lvl),
    .rise(), .fall(sel_fall));
  pin_sync u_din (.mclk(mclk), .rstn(rstn), .pin(port_serial_in), .level_q(din_lvl),
    .rise(), .fall());
  pin_sync u_sda (.mclk(mclk), .rstn(rstn), .pin(sda_in), .level_q(sda_lvl),
    .rise(sda_rise), .fall(sda_fall));
  pin_sync u_ad1 (.mclk(mclk), .rstn(rstn), .pin(address_strap_1), .level_q(ad1_lvl),
    .rise(), .fall());
  wire pre_lvl;
  pin_sync u_pre (.mclk(mclk), .rstn(rstn), .pin(preemp_indicator_pin), .level_q(pre_lvl),
    .rise(), .fall());

  // ==========================================================
  // Mode pick and strap capture
  // ==========================================================
  reg ad2_q;
  reg strap_done_q;
  reg [1:0] start_q;
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      spi_mode_q <= 1'b0;
      ad2_q <= 1'b0;
      strap_done_q <= 1'b0;
      start_q <= 2'h0;
    end
    else
    begin
      if (start_q != 2'h3)
        start_q <= start_q + 2'h1;
      if (!strap_done_q && start_q == 2'h2)
      begin
        ad2_q <= pre_lvl;
        strap_done_q <= 1'b1;
      end
      if (sel_fall && start_q == 2'h3)
        spi_mode_q <= 1'b1;
    end
  end
  wire [6:0] twi_addr = {`TWI_ADDR_HI, ad2_q, ad1_lvl, sel_lvl};

  // ==========================================================
  // Shared byte engine
  // ==========================================================
  localparam ST_ADDR = 3'h0;
  localparam ST_PTR = 3'h1;
  localparam ST_WDATA = 3'h2;
  localparam ST_RDATA = 3'h3;
  localparam ST_IGNORE = 3'h4;
  reg [2:0] state_q;
  reg [2:0] bit_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg ack_phase_q;
  reg twi_active_q;
  reg twi_rd_q;
  wire [7:0] byte_in = {shift_q[6:0], (spi_mode_q ? din_lvl : sda_lvl)};
  wire spi_sel = spi_mode_q & ~sel_lvl;
  wire twi_start = ~spi_mode_q & clk_lvl & sda_fall;
  wire twi_stop = ~spi_mode_q & clk_lvl & sda_rise;
  wire autostep = pointer_q[`PTR_AUTOSTEP_BIT];
  wire [6:0] ptr_next = autostep ? pointer_q[6:0] + 7'h01 : pointer_q[6:0];

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_ADDR;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      pointer_q <= `PTR_RESET;
      wr_data <= 8'h00;
      wr_addr <= 7'h00;
      wr_strobe <= 1'b0;
      port_serial_out <= 1'b1;
      port_serial_out_oe_n <= 1'b1;
      sda_out <= 1'b1;
      sda_oe_n <= 1'b1;
      ack_phase_q <= 1'b0;
      twi_active_q <= 1'b0;
      twi_rd_q <= 1'b0;
    end
    else
    begin
      wr_strobe <= 1'b0;
      if (spi_mode_q)
      begin
        if (sel_lvl)
        begin
          state_q <= ST_ADDR;
          bit_q <= 3'h0;
          port_serial_out_oe_n <= 1'b1;
        end
        else if (spi_sel && clk_rise)
        begin
          shift_q <= byte_in;
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7)
          begin
            case (state_q)
              ST_ADDR:
                if (byte_in[7:1] != `SPI_CHIP_ADDR)
                  state_q <= ST_IGNORE;
                else if (byte_in[0])
                begin
                  state_q <= ST_RDATA;
                  tx_q <= rd_data;
                end
                else
                  state_q <= ST_PTR;
              ST_PTR:
              begin
                pointer_q <= byte_in;
                state_q <= ST_WDATA;
              end
              ST_WDATA:
              begin
                wr_data <= byte_in;
                wr_addr <= pointer_q[6:0];
                wr_strobe <= 1'b1;
                pointer_q[6:0] <= ptr_next;
              end
              ST_RDATA:
                pointer_q[6:0] <= ptr_next;
              default:
                state_q <= ST_IGNORE;
            endcase
          end
        end
        else if (spi_sel && clk_fall && state_q == ST_RDATA)
        begin
          port_serial_out_oe_n <= 1'b0;
          if (bit_q == 3'h0)
          begin
            port_serial_out <= rd_data[7];
            tx_q <= {rd_data[6:0], 1'b0};
          end
          else
          begin
            port_serial_out <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        else if (state_q != ST_RDATA)
          port_serial_out_oe_n <= 1'b1;
      end
      else
      begin
        if (twi_start || twi_stop)
        begin
          state_q <= ST_ADDR;
          bit_q <= 3'h0;
          ack_phase_q <= twi_start;
          twi_active_q <= twi_start;
          sda_oe_n <= 1'b1;
        end
        else if (twi_active_q && clk_rise)
        begin
          if (ack_phase_q)
          begin
            if (twi_rd_q && state_q == ST_RDATA && sda_lvl)
              twi_active_q <= 1'b0;
          end
          else
          begin
            shift_q <= byte_in;
            bit_q <= bit_q + 3'h1;
          end
        end
        else if (twi_active_q && clk_fall)
        begin
          if (!ack_phase_q && bit_q == 3'h0 && state_q != ST_RDATA)
          begin
            ack_phase_q <= 1'b1;
            case (state_q)
              ST_ADDR:
                if (shift_q[7:1] == twi_addr)
                begin
                  sda_oe_n <= 1'b0;
                  sda_out <= 1'b0;
                  twi_rd_q <= shift_q[0];
                  state_q <= shift_q[0] ? ST_RDATA : ST_PTR;
                end
                else
                  twi_active_q <= 1'b0;
              ST_PTR:
              begin
                pointer_q <= shift_q;
                sda_oe_n <= 1'b0;
                sda_out <= 1'b0;
                state_q <= ST_WDATA;
              end
              default:
              begin
                wr_data <= shift_q;
                wr_addr <= pointer_q[6:0];
                wr_strobe <= 1'b1;
                pointer_q[6:0] <= ptr_next;
                sda_oe_n <= 1'b0;
                sda_out <= 1'b0;
              end
            endcase
          end
          else if (state_q == ST_RDATA)
          begin
            if (ack_phase_q)
            begin
              ack_phase_q <= 1'b0;
              sda_oe_n <= 1'b0;
              sda_out <= rd_data[7];
              tx_q <= {rd_data[6:0], 1'b0};
              bit_q <= 3'h0;
            end
            else if (bit_q == 3'h0)
            begin
              sda_oe_n <= 1'b1;
              ack_phase_q <= 1'b1;
              pointer_q[6:0] <= ptr_next;
            end
            else
            begin
              sda_out <= tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          else if (ack_phase_q)
          begin
            ack_phase_q <= 1'b0;
            sda_oe_n <= 1'b1;
          end
        end
      end
    end
  end

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rd_addr <= 7'h00;
    else
      rd_addr <= pointer_q[6:0];
  end

  // ==========================================================
  // Alert pin
  // ==========================================================
  wire [7:0] hits;
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_ALERT_SRC; gi = gi + 1)
    begin : g_src
      alert_source u_src (.mclk(mclk), .rstn(rstn), .src(alert_src[gi]),
        .mask_en(alert_mask[gi]), .mode(alert_mode[2*gi+1:2*gi]), .hit(hits[gi]));
    end
  endgenerate
  wire any_hit = |hits;
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      alert_out <= 1'b0;
      alert_oe_n <= 1'b0;
    end
    else
    begin
      case (alert_pin_style)
        `ALERT_ACT_HIGH:
        begin
          alert_out <= any_hit;
          alert_oe_n <= 1'b0;
        end
        `ALERT_ACT_LOW:
        begin
          alert_out <= ~any_hit;
          alert_oe_n <= 1'b0;
        end
        `ALERT_OPEN_DRAIN:
        begin
          alert_out <= 1'b0;
          alert_oe_n <= ~any_hit;
        end
        default:
        begin
          alert_out <= 1'b0;
          alert_oe_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // dual_mode_control_port

// ### design/dual_mode_control_port_regs.vh
// Constants for the dual mode control port
`ifndef DUAL_MODE_CONTROL_PORT_REGS_VH
`define DUAL_MODE_CONTROL_PORT_REGS_VH
`define SPI_CHIP_ADDR 7'h10
`define TWI_ADDR_HI 4'h2
`define PTR_AUTOSTEP_BIT 7
`define PTR_RESET 8'h00
`define ALERT_ACT_HIGH 2'h0
`define ALERT_ACT_LOW 2'h1
`define ALERT_OPEN_DRAIN 2'h2
`define ALERT_MODE_RISE 2'h0
`define ALERT_MODE_FALL 2'h1
`define ALERT_MODE_LEVEL 2'h2
`define NUM_ALERT_SRC 8
`endif

// ### design/pin_sync.v
// Two-stage synchroniser with edge detection on the second stage
`timescale 1ns/1ns
module pin_sync
(
  input wire mclk,
  input wire rstn,
  input wire pin,
  output reg level_q,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg last_q;
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= 1'b1;
      level_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= pin;
      level_q <= meta_q;
      last_q <= level_q;
    end
  end
  assign rise = level_q & ~last_q;
  assign fall = ~level_q & last_q;
endmodule // pin_sync

// ### design/alert_source.v
// One interrupt source: edge or level trigger with mask
`timescale 1ns/1ns
`include "dual_mode_control_port_regs.vh"
module alert_source
(
  input wire mclk,
  input wire rstn,
  input wire src,
  input wire mask_en,
  input wire [1:0] mode,
  output wire hit
);
  reg prev_q;
  reg trig;
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      prev_q <= 1'b0;
    else
      prev_q <= src;
  end
  always @*
  begin
    case (mode)
      `ALERT_MODE_RISE: trig = src & ~prev_q;
      `ALERT_MODE_FALL: trig = ~src & prev_q;
      `ALERT_MODE_LEVEL: trig = src;
      default: trig = 1'b0;
    endcase
  end
  assign hit = trig & mask_en;
endmodule // alert_source

// ### verification/dual_mode_control_port_assertions.sv
// Concurrent checks on the control port pins
`timescale 1ns/1ns
module dual_mode_control_port_assertions
(
  input wire mclk,
  input wire rstn,
  input wire select_strap_pin,
  input wire port_serial_out_oe_n,
  input wire spi_mode_q,
  input wire wr_strobe,
  input wire [6:0] wr_addr,
  input wire [7:0] pointer_q,
  input wire [7:0] alert_src,
  input wire [7:0] alert_mask,
  input wire [15:0] alert_mode,
  input wire [1:0] alert_pin_style,
  input wire alert_out,
  input wire alert_oe_n
);
  // ==========
  // Properties
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_sel_idle;
    (spi_mode_q && select_strap_pin) [*6];
  endsequence
  sequence s_lvl;
    (alert_mask[0] && alert_mode[1:0] == 2'h2 && alert_src[0] && alert_pin_style == 2'h0) [*4];
  endsequence
  sequence s_off;
    (alert_mask == 8'h00 && alert_pin_style == 2'h0) [*4];
  endsequence
  property p_sel_hiz;
    s_sel_idle |-> port_serial_out_oe_n;
  endproperty
  a_sel_hiz: assert property (p_sel_hiz) else $error("spi out driven after release");
  property p_sticky;
    spi_mode_q |=> spi_mode_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("spi mode lost");
  property p_twi_quiet;
    !spi_mode_q |-> port_serial_out_oe_n;
  endproperty
  a_twi_quiet: assert property (p_twi_quiet) else $error("spi out driven in two-wire");
  property p_od;
    (alert_pin_style == 2'h2) [*2] |-> alert_oe_n || !alert_out;
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_drive;
    (!alert_pin_style[1]) [*2] |-> !alert_oe_n;
  endproperty
  a_drive: assert property (p_drive) else $error("alert pin not driven");
  property p_rel;
    (alert_pin_style == 2'h3) [*2] |-> alert_oe_n;
  endproperty
  a_rel: assert property (p_rel) else $error("alert pin not released");
  property p_masked;
    s_off |-> !alert_out;
  endproperty
  a_masked: assert property (p_masked) else $error("masked alert raised");
  property p_level;
    s_lvl |-> alert_out;
  endproperty
  a_level: assert property (p_level) else $error("level alert missing");
  property p_step;
    wr_strobe |-> ##[0:3] pointer_q[6:0] == (pointer_q[7] ? wr_addr + 7'h1 : wr_addr);
  endproperty
  a_step: assert property (p_step) else $error("pointer step wrong");
  property p_pulse;
    wr_strobe |=> !wr_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("write strobe too long");
endmodule // dual_mode_control_port_assertions
bind dual_mode_control_port dual_mode_control_port_assertions i_chk (
  .mclk(mclk), .rstn(rstn),
  .select_strap_pin(select_strap_pin), .port_serial_out_oe_n(port_serial_out_oe_n),
  .spi_mode_q(spi_mode_q), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .pointer_q(pointer_q),
  .alert_src(alert_src), .alert_mask(alert_mask), .alert_mode(alert_mode),
  .alert_pin_style(alert_pin_style), .alert_out(alert_out), .alert_oe_n(alert_oe_n));

// ### verification/host_model.sv
// Host model driving the link in either mode
`timescale 1ns/1ns
module host_model
(
  input wire mclk,
  input wire so_line,
  input wire sda_line,
  output logic bit_clk,
  output logic din,
  output logic sel,
  output logic sda_h
);
  // ==========
  // Link tasks
  localparam int HALF = 4;
  initial
  begin
    bit_clk = 1'b0;
    din = 1'b0;
    sel = 1'b1;
    sda_h = 1'b1;
  end
  task automatic hwait(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic set_lines(input logic s, input logic c);
    sel = s;
    bit_clk = c;
  endtask
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      din = tx[i];
      hwait(HALF);
      bit_clk = 1'b1;
      rx[i] = so_line;
      hwait(HALF);
      bit_clk = 1'b0;
    end
  endtask
  task automatic tw_start();
    sda_h = 1'b1;
    hwait(HALF / 2);
    bit_clk = 1'b1;
    hwait(HALF);
    sda_h = 1'b0;
    hwait(HALF);
    bit_clk = 1'b0;
  endtask
  task automatic tw_stop();
    sda_h = 1'b0;
    hwait(HALF / 2);
    bit_clk = 1'b1;
    hwait(HALF);
    sda_h = 1'b1;
    hwait(HALF);
  endtask
  task automatic tw_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      hwait(HALF / 2);
      sda_h = tx[i];
      hwait(HALF / 2);
      bit_clk = 1'b1;
      rx[i] = sda_line;
      hwait(HALF);
      bit_clk = 1'b0;
    end
  endtask
endmodule // host_model

// ### verification/dual_mode_control_port_bench.sv
// Self-checking bench for the dual mode control port
`timescale 1ns/1ns
module dual_mode_control_port_bench;
  // ==========
  // Signals
  logic mclk = 0, rstn = 0, address_strap_1 = 0, preemp_indicator_pin = 0, spi_wr = 0;
  logic [7:0] rd_data = 0, alert_src = 0, alert_mask = 0, wd, rx, d;
  logic [15:0] alert_mode = 0;
  logic [1:0] alert_pin_style = 0;
  logic [31:0] seed = 32'h2a50;
  logic [6:0] wa, ra, ta;
  logic [8:0] r9;
  logic [2:0] st;
  wire port_bit_clock, port_serial_in, select_strap_pin, sda_h, port_serial_out;
  wire port_serial_out_oe_n, sda_out, sda_oe_n, wr_strobe, spi_mode_q, alert_out, alert_oe_n;
  wire [7:0] wr_data, pointer_q;
  wire [6:0] wr_addr, rd_addr;
  wire sda_in = sda_h & (sda_oe_n | sda_out);
  wire so_line = port_serial_out_oe_n ? ~port_serial_out : port_serial_out;
  int miscompares = 0, checked = 0, cyc = 0, n1, n2;
  always #20 mclk = ~mclk;
  dual_mode_control_port i_dut (.*);
  host_model i_host (.mclk(mclk), .so_line(so_line), .sda_line(sda_in),
    .bit_clk(port_bit_clock), .din(port_serial_in), .sel(select_strap_pin), .sda_h(sda_h));
  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] reg_val(input logic [6:0] a);
    return {a, 1'b1} ^ 8'h3c;
  endfunction
  function automatic int act();
    if (alert_pin_style == 2'h0)
      return alert_out === 1'b1;
    return alert_out === 1'b0 && alert_oe_n === 1'b0;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic win(input logic v, output int n);
    n = 0;
    alert_src[0] = v;
    repeat (6)
    begin
      @(negedge mclk);
      n += act();
    end
  endtask
  always @(negedge mclk)
  begin
    rd_data <= reg_val(rd_addr);
    cyc++;
    if (wr_strobe === 1'b1)
    begin
      wa = wr_addr;
      wd = wr_data;
    end
    if (spi_wr)
      chk("spi_out_oe_n", port_serial_out_oe_n, 1);
    if (cyc == 60000)
    begin
      miscompares++;
      close_out();
    end
  end
  // ==========
  // Stimulus
  initial
  begin
    st = rnd();
    address_strap_1 = st[1];
    preemp_indicator_pin = st[2];
    @(negedge mclk);
    i_host.set_lines(st[0], 1'b1);
    repeat (7) @(negedge mclk);
    rstn = 1;
    repeat (8) @(negedge mclk);
    preemp_indicator_pin = ~st[2];
    ta = {4'h2, st};
    i_host.tw_start();
    i_host.tw_byte({ta ^ 7'h04, 2'b01}, r9);
    chk("twi_nack", r9[0], 1);
    i_host.tw_stop();
    for (int k = 0; k < 2; k++)
    begin
      ra = rnd();
      d = rnd();
      i_host.tw_start();
      i_host.tw_byte({ta, 2'b01}, r9);
      chk("twi_ack", r9[0], 0);
      i_host.tw_byte({k[0], ra, 1'b1}, r9);
      chk("twi_ptr", pointer_q, {k[0], ra});
      for (int j = 0; j < 2; j++)
      begin
        i_host.tw_byte({8'(d + j), 1'b1}, r9);
        chk("twi_wr_addr", wa, 7'(ra + k * j));
        chk("twi_wr_data", wd, 8'(d + j));
      end
      i_host.tw_stop();
    end
    i_host.tw_start();
    i_host.tw_byte({ta, 2'b01}, r9);
    i_host.tw_byte({1'b1, ra, 1'b1}, r9);
    i_host.tw_stop();
    i_host.tw_start();
    i_host.tw_byte({ta, 2'b11}, r9);
    chk("twi_rd_ack", r9[0], 0);
    i_host.tw_byte(9'h1fe, r9);
    chk("twi_rd0", r9[8:1], reg_val(ra));
    i_host.tw_byte(9'h1ff, r9);
    chk("twi_rd1", r9[8:1], reg_val(ra + 7'h1));
    i_host.tw_stop();
    chk("twi_mode", spi_mode_q, 0);
    rstn = 0;
    i_host.set_lines(1'b1, 1'b0);
    repeat (8) @(negedge mclk);
    rstn = 1;
    repeat (8) @(negedge mclk);
    spi_wr = 1;
    i_host.set_lines(1'b0, 1'b0);
    i_host.spi_byte(8'h23, rx);
    i_host.set_lines(1'b1, 1'b0);
    chk("spi_mode", spi_mode_q, 1);
    for (int k = 0; k < 2; k++)
    begin
      ra = rnd();
      d = rnd();
      i_host.hwait(8);
      i_host.set_lines(1'b0, 1'b0);
      i_host.spi_byte(8'h20, rx);
      i_host.spi_byte({k[0], ra}, rx);
      for (int j = 0; j < 2; j++)
      begin
        i_host.spi_byte(8'(d + j), rx);
        chk("spi_wr_addr", wa, 7'(ra + k * j));
        chk("spi_wr_data", wd, 8'(d + j));
      end
      i_host.set_lines(1'b1, 1'b0);
    end
    spi_wr = 0;
    i_host.hwait(8);
    i_host.set_lines(1'b0, 1'b0);
    i_host.spi_byte(8'h20, rx);
    i_host.spi_byte({1'b1, ra}, rx);
    i_host.set_lines(1'b1, 1'b0);
    i_host.hwait(8);
    i_host.set_lines(1'b0, 1'b0);
    i_host.spi_byte(8'h21, rx);
    i_host.spi_byte(8'h00, rx);
    chk("spi_rd0", rx, reg_val(ra));
    i_host.spi_byte(8'h00, rx);
    chk("spi_rd1", rx, reg_val(ra + 7'h1));
    i_host.set_lines(1'b1, 1'b0);
    i_host.hwait(8);
    chk("spi_release", port_serial_out_oe_n, 1);
    for (int s = 0; s < 3; s++)
      for (int m = 0; m < 4; m++)
      begin
        alert_pin_style = 2'(s);
        alert_mode = {14'(rnd()), 2'(m)};
        alert_mask = 8'h01;
        alert_src = 8'(rnd()) & 8'hfe;
        win(1'b0, n1);
        win(1'b1, n1);
        chk("alert_rise", n1 > 0, m == 0 || m == 2);
        chk("alert_held", act(), m == 2);
        win(1'b0, n2);
        chk("alert_fall", n2 > 0, m == 1);
        alert_mask = 8'h00;
        win(1'b1, n1);
        win(1'b0, n2);
        chk("alert_masked", n1 + n2, 0);
      end
    alert_pin_style = 2'h3;
    repeat (3) @(negedge mclk);
    chk("alert_release", alert_oe_n, 1);
    close_out();
  end
endmodule // dual_mode_control_port_bench
